//--- pkg/urr_pkg.sv
package urr_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam int         APB_AW       = 8;
  localparam int         APB_DW       = 32;
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_INT_STAT = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0C;
  localparam logic [7:0] REG_ERR_CNT  = 8'h10;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int         CTRL_W         = 3;
  localparam int         CTRL_EN_BIT    = 0;
  localparam int         CTRL_OVR_BIT   = 1;
  localparam int         CTRL_MODE6_BIT = 2;
  localparam logic [2:0] CTRL_RESET     = 3'h1;
  localparam int         INT_W          = 3;
  localparam int         INT_UPDATE     = 0;
  localparam int         INT_REJECT     = 1;
  localparam int         INT_CEASE      = 2;
  localparam logic [2:0] INT_RESET      = 3'h0;
  localparam int         ST_IND_BIT     = 8;
  localparam int         ST_STB_BIT     = 9;
  localparam int         ST_MODE6_BIT   = 10;
  localparam int         ST_BUSY_BIT    = 11;
  localparam int         ERR_W          = 8;
  localparam int         CODE_W         = 6;
  localparam logic [5:0] CODE_RESET     = 6'h3F;
  localparam int         RX_W           = 12;
  localparam logic [3:0] BITS5          = 4'h5;
  localparam logic [3:0] BITS6          = 4'h6;
  localparam logic [1:0] PIN_RESET      = 2'h2;

  // ----------------------------------------------------------------
  // Timing, in the unit printed, plus the clock period
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int NS_PER_US     = 1000;
  localparam int NS_PER_MS     = 1000000;
  localparam int STROBE_US     = 60;
  localparam int INDICATOR_MS  = 32;
  localparam int BIT1_MIN_US   = 200;
  localparam int END_MIN_US    = 450;
  localparam int GAP_MAX_US    = 1000;

  function automatic int cyc_least(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  function automatic int cyc_most(input int ns);
    return ns / CLK_PERIOD_NS;
  endfunction

  typedef enum logic [2:0] {
    URR_HUNT = 3'b001,
    URR_DATA = 3'b010,
    URR_END  = 3'b100
  } urr_state_e;

endpackage

//--- rtl/urr_sync.sv
`timescale 1ns/10ps
module urr_sync #(
  parameter int           W       = 2,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_level;

  // A change counts only once the second and third stages agree
  assign next_level = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & level);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1    <= RST_VAL;
      s2    <= RST_VAL;
      s3    <= RST_VAL;
      level <= RST_VAL;
    end else begin
      s1    <= async_in;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end
endmodule // urr_sync

//--- rtl/urr_timer.sv
`timescale 1ns/10ps
module urr_timer #(
  parameter int W = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              expire
);
  logic [W-1:0] cnt;
  logic         at_one;

  assign at_one = (cnt == W'(1));

  // Restart wins over a running count; expire pulses load+1 edges later
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt    <= '0;
      expire <= 1'b0;
    end else begin
      expire <= at_one & ~start;
      if (start) begin
        cnt <= load;
      end else if (cnt != '0) begin
        cnt <= cnt - W'(1);
      end
    end
  end
endmodule // urr_timer

//--- rtl/urr_decoder.sv
`timescale 1ns/10ps
module urr_decoder
  import urr_pkg::*;
#(
  parameter int BIT1_MIN_CYC = cyc_least(BIT1_MIN_US * NS_PER_US),
  parameter int END_MIN_CYC  = cyc_least(END_MIN_US * NS_PER_US),
  parameter int GAP_MAX_CYC  = cyc_most(GAP_MAX_US * NS_PER_US),
  parameter int STROBE_CYC   = cyc_least(STROBE_US * NS_PER_US),
  parameter int IND_CYC      = cyc_least(INDICATOR_MS * NS_PER_MS)
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic                         ultrasonic_in,
  input  wire logic                         mode_5_6_in,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [urr_pkg::APB_AW-1:0]   paddr,
  input  wire logic [urr_pkg::APB_DW-1:0]   pwdata,
  output logic      [urr_pkg::APB_DW-1:0]   prdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic      [urr_pkg::CODE_W-1:0]   code_out,
  output logic                              received_indicator,
  output logic                              strobe_out,
  output logic                              irq
);
  import urr_pkg::*;

  localparam int CNT_W = $clog2(GAP_MAX_CYC + 1);
  localparam int STB_W = $clog2(STROBE_CYC + 1);
  localparam int IND_W = $clog2(IND_CYC + 1);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Each data bit travels with its complement in the second half
  function automatic logic check_ok(input logic [RX_W-1:0] rx,
                                    input logic            m6);
    if (m6) begin
      return rx[11:6] == ~rx[5:0];
    end
    return rx[9:5] == ~rx[4:0];
  endfunction

  function automatic logic [CODE_W-1:0] code_of(
      input logic [RX_W-1:0] rx,
      input logic            m6);
    if (m6) begin
      return rx[5:0];
    end
    return {1'b0, rx[4:0]};
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_lvl;

  urr_sync #(
    .W       (2),
    .RST_VAL (PIN_RESET)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({mode_5_6_in, ultrasonic_in}),
    .level    (pin_lvl)
  );

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl;
  logic [INT_W-1:0]  int_stat;
  logic [INT_W-1:0]  int_mask;
  logic [ERR_W-1:0]  err_cnt;
  urr_state_e        state;
  urr_state_e        next_state;
  logic [3:0]        bit_cnt;
  logic [3:0]        next_bit_cnt;
  logic [RX_W-1:0]   rx_bits;
  logic [RX_W-1:0]   next_rx;
  logic              commit;
  logic              reject;
  logic              us_prev;
  logic [CNT_W-1:0]  burst_cnt;
  logic [CNT_W-1:0]  gap_cnt;
  logic              stb_expire;
  logic              ind_expire;

  wire us_lvl    = pin_lvl[0];
  wire enabled   = ctrl[CTRL_EN_BIT];
  // Open mode pin reads high and selects 5-bit words
  wire mode6     = ctrl[CTRL_OVR_BIT] ? ctrl[CTRL_MODE6_BIT]
                                      : ~pin_lvl[1];
  wire [3:0] nbits  = mode6 ? BITS6 : BITS5;
  wire [3:0] two_n  = {nbits[2:0], 1'b0};
  wire       busy   = (state == URR_DATA) && (bit_cnt != 4'h0);

  // ----------------------------------------------------------------
  // Burst and gap measurement
  // ----------------------------------------------------------------
  // Short burst is a zero, long burst a one, very long the end code
  wire burst_end = us_prev & ~us_lvl;
  wire end_mid   = us_lvl & (burst_cnt == CNT_W'(END_MIN_CYC - 1));
  wire gap_over  = ~us_lvl & (gap_cnt == CNT_W'(GAP_MAX_CYC - 1));
  wire bit_val   = (burst_cnt >= CNT_W'(BIT1_MIN_CYC));
  wire too_long  = (burst_cnt >= CNT_W'(END_MIN_CYC));
  wire burst_max = &burst_cnt;
  wire gap_max   = &gap_cnt;

  wire [CNT_W-1:0] next_burst =
    !us_lvl   ? '0 :
    burst_max ? burst_cnt : burst_cnt + CNT_W'(1);
  wire [CNT_W-1:0] next_gap =
    us_lvl  ? '0 :
    gap_max ? gap_cnt : gap_cnt + CNT_W'(1);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      us_prev   <= 1'b0;
      burst_cnt <= '0;
      gap_cnt   <= '0;
    end else begin
      us_prev   <= us_lvl;
      burst_cnt <= next_burst;
      gap_cnt   <= next_gap;
    end
  end

  // ----------------------------------------------------------------
  // Block framing state machine
  // ----------------------------------------------------------------
  wire block_good = (bit_cnt == two_n) && check_ok(rx_bits, mode6);

  always_comb begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_rx      = rx_bits;
    commit       = 1'b0;
    reject       = 1'b0;
    if (!enabled) begin
      next_state   = URR_HUNT;
      next_bit_cnt = 4'h0;
    end else begin
      case (state)
        URR_HUNT: begin
          // Resynchronise on an end code or a long silence
          if (end_mid) begin
            next_state = URR_END;
          end else if (gap_over) begin
            next_state   = URR_DATA;
            next_bit_cnt = 4'h0;
          end
        end
        URR_DATA: begin
          if (end_mid) begin
            if (block_good) begin
              commit = 1'b1;
            end else begin
              reject = 1'b1;
            end
            next_state = URR_END;
          end else if (gap_over) begin
            reject       = (bit_cnt != 4'h0);
            next_bit_cnt = 4'h0;
          end else if (burst_end && !too_long) begin
            if (bit_cnt == two_n) begin
              reject     = 1'b1;
              next_state = URR_HUNT;
            end else begin
              next_rx[bit_cnt] = bit_val;
              next_bit_cnt     = bit_cnt + 4'h1;
            end
          end
        end
        URR_END: begin
          // Repeated blocks follow straight after the end code
          if (burst_end) begin
            next_state   = URR_DATA;
            next_bit_cnt = 4'h0;
          end
        end
        default: begin
          next_state   = URR_HUNT;
          next_bit_cnt = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state   <= URR_HUNT;
      bit_cnt <= 4'h0;
      rx_bits <= '0;
    end else begin
      state   <= next_state;
      bit_cnt <= next_bit_cnt;
      rx_bits <= next_rx;
    end
  end

  // ----------------------------------------------------------------
  // Code outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      code_out <= CODE_RESET;
    end else if (commit) begin
      code_out <= code_of(rx_bits, mode6);
    end
  end

  // ----------------------------------------------------------------
  // Received indicator and strobe
  // ----------------------------------------------------------------
  // Any high cycle of the synchronised level us_lvl counts as activity and restarts the hold-off
  urr_timer #(
    .W (IND_W)
  ) u_ind_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (us_lvl | commit),
    .load    (IND_W'(IND_CYC - 1)),
    .expire  (ind_expire)
  );

  wire stb_start = commit | (stb_expire & ~strobe_out);

  urr_timer #(
    .W (STB_W)
  ) u_stb_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (stb_start),
    .load    (STB_W'(STROBE_CYC - 1)),
    .expire  (stb_expire)
  );

  wire cease = ind_expire & received_indicator & ~commit;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      received_indicator <= 1'b0;
      strobe_out         <= 1'b0;
    end else begin
      if (commit) begin
        received_indicator <= 1'b1;
      end else if (ind_expire) begin
        received_indicator <= 1'b0;
      end
      // A fresh update restarts the pulse from its clamped phase
      if (commit) begin
        strobe_out <= 1'b0;
      end else if (stb_expire) begin
        strobe_out <= ~strobe_out;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state, writes land on the pready edge
  // ----------------------------------------------------------------
  wire apb_acc  = psel & penable;
  wire apb_new  = apb_acc & ~pready;
  wire apb_done = apb_acc & pready;
  wire wr_en    = apb_done & pwrite;

  wire hit_ctrl  = (paddr == REG_CTRL);
  wire hit_stat  = (paddr == REG_STATUS);
  wire hit_istat = (paddr == REG_INT_STAT);
  wire hit_imask = (paddr == REG_INT_MASK);
  wire hit_err   = (paddr == REG_ERR_CNT);
  wire addr_ok   = hit_ctrl | hit_stat | hit_istat | hit_imask | hit_err;

  wire [APB_DW-1:0] status_word =
      APB_DW'(code_out)
    | (APB_DW'(received_indicator) << ST_IND_BIT)
    | (APB_DW'(strobe_out)         << ST_STB_BIT)
    | (APB_DW'(mode6)              << ST_MODE6_BIT)
    | (APB_DW'(busy)               << ST_BUSY_BIT);

  wire [APB_DW-1:0] rdata =
    hit_ctrl  ? APB_DW'(ctrl)     :
    hit_stat  ? status_word       :
    hit_istat ? APB_DW'(int_stat) :
    hit_imask ? APB_DW'(int_mask) :
    hit_err   ? APB_DW'(err_cnt)  : '0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= apb_new;
      pslverr <= apb_new & ~addr_ok;
      if (apb_new) begin
        prdata <= pwrite ? '0 : rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control, interrupt and error registers
  // ----------------------------------------------------------------
  wire [INT_W-1:0] events = {cease, reject, commit};
  wire [INT_W-1:0] w1c    = (wr_en & hit_istat) ? pwdata[INT_W-1:0]
                                                : '0;
  // Set beats clear when both land in one cycle
  wire [INT_W-1:0] next_int_stat = (int_stat & ~w1c) | events;
  wire err_sat = &err_cnt;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl     <= CTRL_RESET;
      int_mask <= INT_RESET;
      int_stat <= INT_RESET;
      err_cnt  <= '0;
      irq      <= 1'b0;
    end else begin
      if (wr_en && hit_ctrl) begin
        ctrl <= pwdata[CTRL_W-1:0];
      end
      if (wr_en && hit_imask) begin
        int_mask <= pwdata[INT_W-1:0];
      end
      int_stat <= next_int_stat;
      if (reject && !err_sat) begin
        err_cnt <= err_cnt + ERR_W'(1);
      end
      irq <= |(int_stat & int_mask);
    end
  end

endmodule // urr_decoder

//--- verification/urr_decoder_props.sv
`timescale 1ns/10ps
module urr_decoder_props #(
  parameter int IND_CYC = 40
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       ultrasonic_in,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [5:0] code_out,
  input wire logic       received_indicator,
  input wire logic       strobe_out
);
  // ----------------------------------------------------------------
  // Helper: cycles since the pin last carried a pulse train
  // ----------------------------------------------------------------
  int quiet_cnt;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) quiet_cnt <= 0;
    else if (ultrasonic_in) quiet_cnt <= 0;
    else if (quiet_cnt < 1000) quiet_cnt <= quiet_cnt + 1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_reset_clear;
    $fell(rst) |-> code_out == 6'h3F && !received_indicator && !strobe_out;
  endproperty
  // Pin is sampled four cycles back: the syncer delays what the FSM sees
  property p_code_end;
    !$stable(code_out) |-> $past(ultrasonic_in, 4) && received_indicator;
  endproperty
  property p_strobe_delay;
    $rose(received_indicator) |-> !strobe_out [*6] ##1 strobe_out;
  endproperty
  property p_strobe_width;
    $rose(strobe_out) |-> strobe_out [*6] ##1 !strobe_out;
  endproperty
  // Pin seen five cycles back: the hold-off restart lags the syncer, so a
  // burst that starts as the hold-off ends may not rescue the indicator
  property p_ind_hold;
    received_indicator && $past(ultrasonic_in, 5)
      |=> received_indicator [*8];
  endproperty
  property p_ind_cease;
    quiet_cnt == IND_CYC + 6 |-> !received_indicator;
  endproperty
  property p_apb_wait;
    psel && penable && !pready |=> pready;
  endproperty
  property p_pready_one;
    pready |=> !pready;
  endproperty
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty

  a_reset_clear: assert property (p_reset_clear) else $error("bad reset");
  a_code_end: assert property (p_code_end) else $error("code moved");
  a_strobe_delay: assert property (p_strobe_delay) else $error("strobe");
  a_strobe_width: assert property (p_strobe_width) else $error("width");
  a_ind_hold: assert property (p_ind_hold) else $error("ind dropped");
  a_ind_cease: assert property (p_ind_cease) else $error("ind stuck");
  a_apb_wait: assert property (p_apb_wait) else $error("no ready");
  a_pready_one: assert property (p_pready_one) else $error("long ready");
  a_err_with_ready: assert property (p_err_with_ready) else $error("err");

  c_update: cover property (!$stable(code_out));
  c_strobe: cover property ($rose(strobe_out));
  c_cease: cover property ($fell(received_indicator));
  c_err: cover property (pslverr);
endmodule // urr_decoder_props

bind urr_decoder urr_decoder_props #(.IND_CYC(IND_CYC)) u_props (
  .clk_sys(clk_sys), .rst(rst), .ultrasonic_in(ultrasonic_in),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .code_out(code_out), .received_indicator(received_indicator),
  .strobe_out(strobe_out));

//--- verification/urr_tx_model.sv
`timescale 1ns/10ps
module urr_tx_model (
  input  wire logic       clk_sys,
  input  wire logic       start,
  input  wire logic [5:0] code,
  input  wire logic       six,
  input  wire logic       bad,
  input  wire logic [1:0] reps,
  output logic            us_out,
  output logic            busy
);
  int nb;

  // Burst lengths: 2 = zero, 6 = one, 16 = end code; gaps of 3
  task automatic burst(input int len);
    us_out <= 1'b1;
    repeat (len) @(posedge clk_sys);
    us_out <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  initial begin
    us_out = 1'b0;
    busy   = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (start) begin
        busy <= 1'b1;
        nb = six ? 6 : 5;
        repeat (reps) begin
          for (int i = 0; i < nb; i++) burst(code[i] ? 6 : 2);
          // Corruption breaks only the first check bit
          for (int i = 0; i < nb; i++)
            burst((code[i] ^ (bad && i == 0)) ? 2 : 6);
          burst(16);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule // urr_tx_model

//--- verification/ultrasonic_remote_receiver_decoder_tb.sv
`timescale 1ns/10ps
module ultrasonic_remote_receiver_decoder_tb;
  import urr_pkg::*;
  logic        clk_sys = 0;
  logic        rst = 1;
  logic        ultrasonic_in;
  logic        mode_5_6_in = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic        pready, pslverr, received_indicator, strobe_out, irq;
  logic [5:0]  code_out;
  logic        tx_start = 0;
  logic [5:0]  tx_code = 0;
  logic        tx_bad = 0;
  logic [1:0]  tx_reps = 1;
  logic        tx_busy;
  logic [31:0] rd;
  logic        er;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cyc = 0;

  always #4 clk_sys = ~clk_sys;

  urr_decoder #(.BIT1_MIN_CYC(4), .END_MIN_CYC(10), .GAP_MAX_CYC(20),
    .STROBE_CYC(6), .IND_CYC(40)) DUT (
    .clk_sys(clk_sys), .rst(rst), .ultrasonic_in(ultrasonic_in),
    .mode_5_6_in(mode_5_6_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .code_out(code_out),
    .received_indicator(received_indicator), .strobe_out(strobe_out),
    .irq(irq));

  urr_tx_model u_tx (.clk_sys(clk_sys), .start(tx_start), .code(tx_code),
    .six(~mode_5_6_in), .bad(tx_bad), .reps(tx_reps),
    .us_out(ultrasonic_in), .busy(tx_busy));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the bench ceiling ends a wait that never sees pready
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd, er);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, rd, er);
    chk(rd, exp);
  endtask

  task automatic send(input logic [5:0] c, input logic b,
                      input logic [1:0] n);
    tx_code <= c;
    tx_bad <= b;
    tx_reps <= n;
    tx_start <= 1'b1;
    @(posedge clk_sys);
    tx_start <= 1'b0;
    @(posedge clk_sys);
    while (tx_busy !== 1'b0) begin
      @(posedge clk_sys);
    end
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic end_test(input string name);
    $display("test %0s done", name);
  endtask

  // Ceiling: about two hundred blocks of 89 to 103 cycles each
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk(code_out, 32'h3F);
    chk(received_indicator, 32'h0);
    chk(strobe_out, 32'h0);
    rd_chk(REG_CTRL, 32'h1);
    rd_chk(REG_INT_MASK, 32'h0);
    end_test("reset");
    send(6'h13, 1'b0, 2'd2);
    chk(code_out, 32'h13);
    chk(received_indicator, 32'h1);
    end_test("five_bit");
    send(6'h0C, 1'b1, 2'd1);
    chk(code_out, 32'h13);
    rd_chk(REG_ERR_CNT, 32'h1);
    send(6'h0A, 1'b0, 2'd1);
    chk(code_out, 32'h0A);
    rd_chk(REG_INT_STAT, 32'h3);
    end_test("reject");
    wr(REG_INT_MASK, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk(irq, 32'h1);
    wr(REG_INT_STAT, 32'h7);
    repeat (3) @(posedge clk_sys);
    chk(irq, 32'h0);
    xfer(1'b0, 8'h20, 32'h0, rd, er);
    chk(er, 32'h1);
    chk(rd, 32'h0);
    end_test("irq");
    mode_5_6_in <= 1'b0;
    repeat (10) @(posedge clk_sys);
    send(6'h2A, 1'b0, 2'd1);
    chk(code_out, 32'h2A);
    end_test("six_bit");
    repeat (60) @(posedge clk_sys);
    chk(received_indicator, 32'h0);
    rd_chk(REG_INT_STAT, 32'h5);
    rd_chk(REG_STATUS, 32'h42A);
    end_test("cease");
    // With the receiver disabled no block may be taken or refused
    wr(REG_CTRL, 32'h0);
    send(6'h15, 1'b0, 2'd2);
    chk(code_out, 32'h2A);
    chk(received_indicator, 32'h0);
    rd_chk(REG_ERR_CNT, 32'h1);
    end_test("disable");
    report_and_stop;
  end
endmodule // ultrasonic_remote_receiver_decoder_tb
